// file: rtl/flash_self_program_sections.sv
// section-aware flash self-programming control with AHB-Lite registers
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`include "flash_sections_params.svh"
`timescale 1ns/10ps
`default_nettype none

module flash_self_program_sections
  import flash_sections_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  clk_en,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  spm_valid,
  input  wire logic [1:0]            spm_op,
  input  wire logic [`FS_ADDR_W-1:0] spm_addr,
  input  wire logic [`FS_ADDR_W-1:0] cpu_pc,
  input  wire logic [1:0]            boot_size_fuses,
  input  wire logic [1:0]            app_lock_bits,
  input  wire logic [1:0]            boot_lock_bits,
  output logic                       cpu_stall,
  output logic                       concurrent_region_busy,
  output logic                       flash_erase,
  output logic                       flash_write,
  output logic [`FS_ADDR_W-1:0]      flash_page_addr,
  output logic                       irq
);

  // ****************************************
  // section decode
  // ****************************************
  logic [`FS_ADDR_W-1:0] boot_base;
  logic pc_in_boot;
  logic tgt_in_boot;
  logic tgt_in_halt;
  logic tgt_locked;

  // fuse-selected split; every base sits at or above the halting base
  always_comb begin
    case (boot_size_fuses)
      2'h0:    boot_base = `FS_BOOT_BASE_0;
      2'h1:    boot_base = `FS_BOOT_BASE_1;
      2'h2:    boot_base = `FS_BOOT_BASE_2;
      default: boot_base = `FS_BOOT_BASE_3;
    endcase
  end

  // issuer must sit in the boot loader section
  assign pc_in_boot  = (cpu_pc >= boot_base);
  assign tgt_in_boot = (spm_addr >= boot_base);
  // fixed region boundary; the target address picks the region
  assign tgt_in_halt = (spm_addr >= `FS_HALT_BASE);
  // lock bit0 low forbids erase and write, independently per section
  assign tgt_locked  = tgt_in_boot ? ~boot_lock_bits[0] : ~app_lock_bits[0];

  // ****************************************
  // programming sequencer
  // ****************************************
  prog_state_t           state_q, state_d;
  logic [`FS_CNT_W-1:0]  cnt_q, cnt_d;
  logic                  halt_q, halt_d;
  logic                  busy_q, busy_d;
  logic                  erase_q, erase_d;
  logic                  write_q, write_d;
  logic [`FS_ADDR_W-1:0] page_q, page_d;
  logic                  ev_done, ev_reject;
  logic                  is_prog, reenable_wr;

  assign is_prog = spm_valid && (spm_op == OP_ERASE || spm_op == OP_WRITE);

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    halt_d    = halt_q;
    busy_d    = busy_q;
    erase_d   = 1'b0;
    write_d   = 1'b0;
    page_d    = page_q;
    ev_done   = 1'b0;
    ev_reject = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (is_prog && pc_in_boot && !tgt_locked) begin
          // any page may be targeted; page-aligned address
          page_d  = {spm_addr[`FS_ADDR_W-1:`FS_PAGE_W], {`FS_PAGE_W{1'b0}}};
          erase_d = (spm_op == OP_ERASE);
          write_d = (spm_op == OP_WRITE);
          cnt_d   = (spm_op == OP_ERASE) ? `FS_ERASE_CYC : `FS_WRITE_CYC;
          halt_d  = tgt_in_halt;
          // concurrent page sets busy; cpu keeps running
          if (!tgt_in_halt)
            busy_d = 1'b1;
          state_d = ST_PROG;
        end else if (is_prog) begin
          ev_reject = 1'b1;
        end else if (spm_valid && spm_op == OP_LOAD && pc_in_boot) begin
          busy_d = 1'b0;
        end
      end
      ST_PROG: begin
        if (cnt_q <= `FS_CNT_W'(1)) begin
          halt_d  = 1'b0;
          ev_done = 1'b1;
          state_d = ST_DONE;
        end else begin
          cnt_d = cnt_q - `FS_CNT_W'(1);
        end
      end
      ST_DONE: begin
        // re-enable after completion or page load clears busy
        if (reenable_wr || (spm_valid && spm_op == OP_LOAD && pc_in_boot))
          busy_d = 1'b0;
        if (is_prog || reenable_wr || !busy_q)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      halt_q  <= 1'b0;
      busy_q  <= 1'b0;
      erase_q <= 1'b0;
      write_q <= 1'b0;
      page_q  <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      halt_q  <= halt_d;
      busy_q  <= busy_d;
      erase_q <= erase_d;
      write_q <= write_d;
      page_q  <= page_d;
    end
  end

  assign cpu_stall              = halt_q;
  assign concurrent_region_busy = busy_q;
  assign flash_erase            = erase_q;
  assign flash_write            = write_q;
  assign flash_page_addr        = page_q;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic                   ap_wr_q, ap_wr_d;
  logic                   ap_rd_q, ap_rd_d;
  logic [7:0]             ap_off_q, ap_off_d;
  logic [`FS_EV_W-1:0]    ist_q, ist_d;
  logic [`FS_EV_W-1:0]    imask_q, imask_d;
  logic [31:0]            rdata_q, rdata_d;
  logic                   irq_q, irq_d;
  logic                   ap_take;

  assign ap_take     = hsel && hready && htrans[1];
  assign reenable_wr = ap_wr_q && (ap_off_q == `FS_OFF_CTRL) && hwdata[`FS_BIT_REENABLE];

  always_comb begin
    ap_wr_d  = ap_take && hwrite;
    ap_rd_d  = ap_take && !hwrite;
    ap_off_d = ap_take ? haddr[7:0] : ap_off_q;
    imask_d  = imask_q;
    ist_d    = ist_q;
    rdata_d  = 32'h0000_0000;
    if (ap_wr_q && ap_off_q == `FS_OFF_IRQ_MASK)
      imask_d = hwdata[`FS_EV_W-1:0];
    if (ap_wr_q && ap_off_q == `FS_OFF_IRQ_STAT)
      ist_d = ist_d & ~hwdata[`FS_EV_W-1:0];
    // set wins over a simultaneous clear
    ist_d[`FS_EV_DONE]   = ist_d[`FS_EV_DONE] | ev_done;
    ist_d[`FS_EV_REJECT] = ist_d[`FS_EV_REJECT] | ev_reject;
    if (ap_rd_d) begin
      case (haddr[7:0])
        `FS_OFF_STAT: begin
          rdata_d[`FS_BIT_BUSY] = busy_q;
          rdata_d[`FS_BIT_HALT] = halt_q;
          rdata_d[`FS_BIT_PROG] = (state_q == ST_PROG);
        end
        `FS_OFF_IRQ_STAT: rdata_d[`FS_EV_W-1:0] = ist_q;
        `FS_OFF_IRQ_MASK: rdata_d[`FS_EV_W-1:0] = imask_q;
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ap_wr_q  <= 1'b0;
      ap_rd_q  <= 1'b0;
      ap_off_q <= 8'h00;
      ist_q    <= '0;
      imask_q  <= '0;
      rdata_q  <= 32'h0000_0000;
      irq_q    <= 1'b0;
    end else if (clk_en) begin
      ap_wr_q  <= ap_wr_d;
      ap_rd_q  <= ap_rd_d;
      ap_off_q <= ap_off_d;
      ist_q    <= ist_d;
      imask_q  <= imask_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
    end
  end

  // zero wait state; hreadyout constant high from a flop
  always_ff @(posedge core_clk) begin
    hreadyout <= 1'b1;
  end
  assign hrdata = rdata_q;
  assign hresp  = 1'b0;
  assign irq    = irq_q;

  // ****************************************
  // checks
  // ****************************************
  a_reject_from_app: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state_q == ST_IDLE && is_prog && !pc_in_boot |=> state_q != ST_PROG)
    else $error("op from application section started programming");
  a_any_target_ok: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state_q == ST_IDLE && is_prog && pc_in_boot && !tgt_locked |=> state_q == ST_PROG)
    else $error("allowed op did not start");
  a_lock_blocks: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state_q == ST_IDLE && is_prog && tgt_locked |=> state_q == ST_IDLE)
    else $error("locked section was programmed");
  a_halt_whole_op: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state_q == ST_PROG && cnt_q > `FS_CNT_W'(1) && cpu_stall |=> cpu_stall)
    else $error("cpu not stalled during halting-region op");
  a_concurrent_runs: assert property (@(posedge core_clk) disable iff (srst)
    state_q == ST_PROG && busy_q |-> !cpu_stall)
    else $error("cpu stalled on concurrent-region op");
  a_boot_in_halt: assert property (@(posedge core_clk) disable iff (srst)
    boot_base >= `FS_HALT_BASE)
    else $error("boot section outside halting region");
  a_busy_set: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state_q == ST_IDLE && is_prog && pc_in_boot && !tgt_locked && !tgt_in_halt
    |=> concurrent_region_busy)
    else $error("busy not set on concurrent-region op");
  a_busy_load_clr: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && state_q != ST_PROG && spm_valid && spm_op == OP_LOAD && pc_in_boot |=> !busy_q)
    else $error("page load did not clear busy");
  c_prog_concurrent: cover property (@(posedge core_clk) state_q == ST_PROG && busy_q);
  c_prog_halt: cover property (@(posedge core_clk) state_q == ST_PROG && halt_q);
  c_reject: cover property (@(posedge core_clk) ev_reject);

endmodule : flash_self_program_sections

`default_nettype wire

// file: pkg/flash_sections_params.svh
// constants for the flash self-programming section controller
`ifndef FLASH_SECTIONS_PARAMS_SVH
`define FLASH_SECTIONS_PARAMS_SVH
`define FS_ADDR_W        13
`define FS_PAGE_W        6
`define FS_HALT_BASE     13'h1800
`define FS_BOOT_BASE_0   13'h1F00
`define FS_BOOT_BASE_1   13'h1E00
`define FS_BOOT_BASE_2   13'h1C00
`define FS_BOOT_BASE_3   13'h1800
`define FS_ERASE_CYC     16'h0010
`define FS_WRITE_CYC     16'h0010
`define FS_CNT_W         16
`define FS_OFF_CTRL      8'h00
`define FS_OFF_STAT      8'h04
`define FS_OFF_IRQ_STAT  8'h08
`define FS_OFF_IRQ_MASK  8'h0C
`define FS_BIT_REENABLE  0
`define FS_BIT_BUSY      0
`define FS_BIT_HALT      1
`define FS_BIT_PROG      2
`define FS_EV_DONE       0
`define FS_EV_REJECT     1
`define FS_EV_W          2
`endif

// file: pkg/flash_sections_pkg.sv
// types for the flash self-programming section controller
package flash_sections_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_DONE = 3'b100
  } prog_state_t;
  typedef enum logic [1:0] {
    OP_LOAD  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10,
    OP_NONE  = 2'b11
  } spm_op_t;
endpackage : flash_sections_pkg

// file: tb/boot_cpu_model.sv
// cpu model that issues store-program-memory ops from a caller-given pc in boot or application code
`include "flash_sections_params.svh"
`timescale 1ns/10ps
`default_nettype none
module boot_cpu_model
  import flash_sections_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  cpu_stall,
  output logic                       spm_valid,
  output logic [1:0]                 spm_op,
  output logic [`FS_ADDR_W-1:0]      spm_addr,
  output logic [`FS_ADDR_W-1:0]      cpu_pc
);
  // between ops the cpu idles in halting boot code
  initial begin
    spm_valid = 1'b0;
    spm_op    = OP_NONE;
    spm_addr  = 13'h0000;
    cpu_pc    = 13'h1FFE;
  end
  task automatic issue(input logic [1:0] op, input logic [12:0] a, input logic [12:0] pc);
    @(posedge core_clk);
    // a halted cpu cannot issue anything
    for (int n = 0; n < 64 && cpu_stall === 1'b1; n++) @(posedge core_clk);
    if (cpu_stall === 1'b1) begin
      flash_self_program_sections_tb.bad_count++;
      flash_self_program_sections_tb.complete_run();
    end
    spm_valid <= 1'b1;
    spm_op    <= op;
    spm_addr  <= a;
    cpu_pc    <= pc;
    @(posedge core_clk);
    // released address shows a changed value, not the old one
    spm_valid <= 1'b0;
    spm_op    <= OP_NONE;
    spm_addr  <= ~a;
    cpu_pc    <= 13'h1FFE;
  endtask : issue
endmodule : boot_cpu_model
`default_nettype wire

// file: tb/flash_self_program_sections_tb.sv
// self-checking bench for the flash section controller
`include "flash_sections_params.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("unexpected %0t %s", $time, m); end end
module flash_self_program_sections_tb
  import flash_sections_pkg::*;
;
  logic        core_clk, srst, hsel, hwrite, hreadyout, hresp, spm_valid, cpu_stall, irq;
  logic        concurrent_region_busy, flash_erase, flash_write;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, boot_size_fuses, app_lock_bits, boot_lock_bits, spm_op;
  logic [12:0] spm_addr, cpu_pc, flash_page_addr, a;
  int          bad_count, comparisons;
  localparam logic [12:0] BASES [4] = '{`FS_BOOT_BASE_0, `FS_BOOT_BASE_1, `FS_BOOT_BASE_2, `FS_BOOT_BASE_3};

  flash_self_program_sections uut (.core_clk, .srst, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .spm_valid, .spm_op,
    .spm_addr, .cpu_pc, .boot_size_fuses, .app_lock_bits, .boot_lock_bits, .cpu_stall,
    .concurrent_region_busy, .flash_erase, .flash_write, .flash_page_addr, .irq);
  boot_cpu_model m (.core_clk, .cpu_stall, .spm_valid, .spm_op, .spm_addr, .cpu_pc);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h000000, ad};
    @(posedge core_clk);
    while (hreadyout !== 1'b1 && n < 50) begin @(posedge core_clk); n++; end
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1 && n < 50) begin @(posedge core_clk); n++; end
    rd = hrdata;
    if (n >= 50) begin bad_count++; complete_run(); end
  endtask : bus

  // one op with the expected outcome worked out from fuses and locks
  task automatic run_op(input logic [1:0] op, input logic [12:0] ad, input logic [12:0] pc);
    logic ok, halt;
    int   n, sc;
    m.issue(op, ad, pc);
    #1;
    halt = ad >= `FS_HALT_BASE;
    ok = pc >= BASES[boot_size_fuses] && (ad >= BASES[boot_size_fuses] ? boot_lock_bits[0] : app_lock_bits[0]);
    if (op == OP_LOAD) begin
      `CHK(concurrent_region_busy, 1'b0, "busy after load")
      return;
    end
    `CHK(flash_erase, ok && op == OP_ERASE, "erase pulse")
    `CHK(flash_write, ok && op == OP_WRITE, "write pulse")
    `CHK(cpu_stall, ok && halt, "stall")
    `CHK(concurrent_region_busy, ok && !halt, "busy set")
    if (ok) `CHK(flash_page_addr, ad & 13'h1FC0, "page base")
    n = 0;
    sc = int'(cpu_stall === 1'b1);
    while (irq !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
      sc += int'(cpu_stall === 1'b1);
    end
    if (n >= 100) begin bad_count++; complete_run(); end
    if (ok && halt) `CHK(sc >= 16 && sc <= 17, 1'b1, "stall length")
    if (ok && !halt) `CHK(sc, 0, "cpu kept running")
    `CHK(concurrent_region_busy, ok && !halt, "busy held")
    bus(1'b0, `FS_OFF_STAT, 0, d);
    `CHK(d[0], ok && !halt, "busy read")
    bus(1'b0, `FS_OFF_IRQ_STAT, 0, d);
    `CHK(d[1:0], {!ok, ok}, "event")
    bus(1'b1, `FS_OFF_IRQ_STAT, 3, d);
    bus(1'b1, `FS_OFF_CTRL, 1, d);
    @(posedge core_clk);
    #1;
    `CHK(concurrent_region_busy, 1'b0, "busy cleared")
    `CHK(irq, 1'b0, "irq cleared")
  endtask : run_op

  initial begin
    void'($urandom(32'hB18ADD85));
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    srst = 1'b1;
    boot_size_fuses = 2'b00;
    app_lock_bits = 2'b11;
    boot_lock_bits = 2'b11;
    bad_count = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    bus(1'b0, `FS_OFF_STAT, 0, d);
    `CHK(d, 32'h00000000, "status after reset")
    `CHK(hresp, 1'b0, "okay response")
    bus(1'b0, 8'h10, 0, d);
    `CHK(d, 32'h00000000, "unmapped read")
    m.issue(OP_ERASE, 13'h0100, 13'h0100);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b0, "masked irq")
    bus(1'b1, `FS_OFF_IRQ_MASK, 3, d);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b1, "unmasked irq")
    bus(1'b1, `FS_OFF_IRQ_STAT, 2, d);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b0, "cleared irq")
    for (int f = 0; f < 4; f++) begin
      boot_size_fuses <= f[1:0];
      a = 13'($urandom_range(0, 32'h17FF));
      run_op(OP_ERASE, a, BASES[f] - 13'h0001);
      run_op(f[0] ? OP_WRITE : OP_ERASE, a, BASES[f]);
      run_op(OP_WRITE, 13'(`FS_HALT_BASE + $urandom_range(0, 32'h07FF)), BASES[f]);
    end
    boot_size_fuses <= 2'b00;
    app_lock_bits <= 2'b10;
    run_op(OP_ERASE, 13'h0040, 13'h1F00);
    run_op(OP_ERASE, 13'h1F40, 13'h1F00);
    app_lock_bits <= 2'b11;
    boot_lock_bits <= 2'b10;
    run_op(OP_WRITE, 13'h1F80, 13'h1F00);
    run_op(OP_WRITE, 13'h0080, 13'h1F00);
    boot_lock_bits <= 2'b11;
    m.issue(OP_ERASE, 13'h0200, 13'h1F00);
    repeat (20) @(posedge core_clk);
    run_op(OP_LOAD, 13'h0200, 13'h1F00);
    complete_run();
  end
endmodule : flash_self_program_sections_tb
`default_nettype wire
